// *** hdl/i2cmce_consts.svh ***
`ifndef I2CMCE_CONSTS_SVH
`define I2CMCE_CONSTS_SVH
// register offsets
`define I2CMCE_OFF_ADDR 8'h00
`define I2CMCE_OFF_CMD 8'h04
`define I2CMCE_OFF_DATA 8'h08
`define I2CMCE_OFF_DIV 8'h0c
`define I2CMCE_OFF_MASK 8'h10
`define I2CMCE_OFF_RAW 8'h14
`define I2CMCE_OFF_MIS 8'h18
`define I2CMCE_OFF_CLR 8'h1c
// command word fields
`define I2CMCE_RUN 0
`define I2CMCE_START 1
`define I2CMCE_STOP 2
`define I2CMCE_ACK 3
// reset values
`define I2CMCE_DIV_RST 8'h01
// fixed phase counts of one scl period
`define I2CMCE_LOW_PHASE 6
`define I2CMCE_HIGH_PHASE 4
`endif

// *** hdl/i2cmce_pkg.sv ***
package i2cmce_pkg;
  // controller state, gray along idle -> transmit -> receive
  typedef enum logic [1:0] {
    I2CMCE_IDLE = 2'b00,
    I2CMCE_MTX = 2'b01,
    I2CMCE_MRX = 2'b11
  } i2cmce_mode_t;
  // bus sequencer phases
  typedef enum logic [2:0] {
    I2CMCE_SQ_IDLE = 3'b000,
    I2CMCE_SQ_START = 3'b001,
    I2CMCE_SQ_ADDR = 3'b011,
    I2CMCE_SQ_DATA = 3'b010,
    I2CMCE_SQ_STOP = 3'b110,
    I2CMCE_SQ_END = 3'b111
  } i2cmce_seq_t;
endpackage

// *** hdl/i2cmce_tick.sv ***
`include "i2cmce_consts.svh"
// quarter-phase tick generator: one tick every 1+divider_value clocks
module i2cmce_tick
  import i2cmce_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic run,
  input wire logic [7:0] divider_value,
  // tick out
  output logic tick
);
  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } i2cmce_tick_st_t;
  i2cmce_tick_st_t s_reg, s_next;
  // count down, restart when idle so phases align with a transfer
  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (!run) begin
      s_next.cnt = divider_value;
    end else if (s_reg.cnt == 8'h00) begin
      s_next.cnt = divider_value;
      s_next.tick = 1'b1;
    end else begin
      s_next.cnt = s_reg.cnt - 8'h01;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  assign tick = s_reg.tick;
endmodule

// *** hdl/i2cmce_sync.sv ***
// three-flop input synchroniser; change accepted when stages 2 and 3 agree
module i2cmce_sync
  import i2cmce_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pin and clean level
  input wire logic pin,
  output logic level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } i2cmce_sync_st_t;
  i2cmce_sync_st_t s_reg, s_next;
  // idle bus is high, so reset to one
  always_comb begin
    s_next = s_reg;
    s_next.s1 = pin;
    s_next.s2 = s_reg.s1;
    s_next.s3 = s_reg.s2;
    if (s_reg.s2 == s_reg.s3) begin
      s_next.lvl = s_reg.s3;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '1;
    end else begin
      s_reg <= s_next;
    end
  end
  assign level = s_reg.lvl;
endmodule

// *** hdl/i2cmce_top.sv ***
// Behaviour
// - transfers need run; else only stop acts
// - idle send start: start, send, maybe stop
// - idle receive start: receive, ack choice, maybe stop
// - transmit, run only: send next byte
// - stop with run sends then stops
// - transmit, send restart: repeated start, send
// - transmit, receive restart: enter receive state
// - receive, run: another byte, optional stop
// - receive, receive restart: repeated start, receive
// - receive, send restart: enter transmit state
// - eight-bit data: transmit source, receive sink
// - mask gates raw interrupt onto output
// - masked bit equals raw and mask
// - writing one to clear drops raw, unless a completion sets it in that cycle
// - interrupt on completion or error abort
//
// Our own choice: the plain strobed port.
`include "i2cmce_consts.svh"
module i2cmce_top
  import i2cmce_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // i2c pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // interrupt
  output logic irq
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0] addr_sel;   // target_address_select
    logic [7:0] data;       // master_data_byte
    logic [7:0] div;        // divider_value
    logic mask;             // promote_enable
    logic raw;              // raw_pending
    i2cmce_mode_t mode;
    i2cmce_seq_t seq;
    logic do_start, do_xfer, do_stop, ack, rx;
    logic [1:0] q;          // quarter within a bit
    logic [4:0] ph;         // tick count within a quarter
    logic [3:0] bitn;       // bit index, 8 = ack slot
    logic [7:0] sh;         // shift register
    logic adr_nak, dat_nak, err;
    logic busy;
    logic [31:0] rdata;
    logic scl_oe, sda_oe;
    logic irq;
  } i2cmce_st_t;
  i2cmce_st_t s_reg, s_next;
  logic tick;
  logic sda_s;
  logic scl_s;
  logic unused_scl;

  // ****************************************
  // helpers
  // ****************************************
  // one quarter of a bit spans (low+high)/2 ticks
  localparam logic [4:0] QTR_TICKS =
    5'((`I2CMCE_LOW_PHASE + `I2CMCE_HIGH_PHASE) / 2);

  // command legality against the table for each state
  function automatic logic cmd_legal(input i2cmce_mode_t m,
                                     input logic [3:0] c,
                                     input logic rs);
    logic r, st, sp, ak;
    r = c[`I2CMCE_RUN];
    st = c[`I2CMCE_START];
    sp = c[`I2CMCE_STOP];
    ak = c[`I2CMCE_ACK];
    cmd_legal = 1'b0;
    case (m)
      I2CMCE_IDLE: begin
        cmd_legal = r && st && !(rs && ak && sp);
      end
      I2CMCE_MTX: begin
        cmd_legal = (!st && (r || sp)) ||
                    (r && st && !(rs && ak && sp));
      end
      default: begin
        cmd_legal = (!st && !r && sp) || (!st && r && !(ak && sp)) ||
                    (st && r && !(rs && ak && sp));
      end
    endcase
  endfunction

  // ****************************************
  // submodules
  // ****************************************
  i2cmce_tick u_tick (
    .clk(clk),
    .rst(rst),
    .run(s_reg.busy),
    .divider_value(s_reg.div),
    .tick(tick)
  );
  i2cmce_sync u_sda (
    .clk(clk),
    .rst(rst),
    .pin(sda_in),
    .level(sda_s)
  );
  // scl kept synchronised for future stretch support
  i2cmce_sync u_scl (
    .clk(clk),
    .rst(rst),
    .pin(scl_in),
    .level(scl_s)
  );
  assign unused_scl = scl_s;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [3:0] c;
    logic qend;
    logic phend;
    c = wdata[3:0];
    s_next = s_reg;
    qend = tick && (s_reg.ph == QTR_TICKS - 5'd1);
    phend = 1'b0;
    // register reads: data one cycle later
    s_next.rdata = 32'h0;
    if (rd) begin
      if (addr == `I2CMCE_OFF_ADDR) begin
        s_next.rdata = {24'h0, s_reg.addr_sel};
      end else if (addr == `I2CMCE_OFF_CMD) begin
        s_next.rdata = {25'h0, 1'b0, s_reg.mode == I2CMCE_IDLE,
                        1'b0, s_reg.dat_nak, s_reg.adr_nak,
                        s_reg.err, s_reg.busy};
      end else if (addr == `I2CMCE_OFF_DATA) begin
        s_next.rdata = {24'h0, s_reg.data};
      end else if (addr == `I2CMCE_OFF_DIV) begin
        s_next.rdata = {24'h0, s_reg.div};
      end else if (addr == `I2CMCE_OFF_MASK) begin
        s_next.rdata = {31'h0, s_reg.mask};
      end else if (addr == `I2CMCE_OFF_RAW) begin
        s_next.rdata = {31'h0, s_reg.raw};
      end else if (addr == `I2CMCE_OFF_MIS) begin
        s_next.rdata = {31'h0, s_reg.raw & s_reg.mask};
      end else begin
        s_next.rdata = 32'h0;   // clear register and unmapped read zero
      end
    end
    // register writes
    if (wr) begin
      if (addr == `I2CMCE_OFF_ADDR && !s_reg.busy) begin
        s_next.addr_sel = wdata[7:0];
      end else if (addr == `I2CMCE_OFF_DATA && !s_reg.busy) begin
        s_next.data = wdata[7:0];
      end else if (addr == `I2CMCE_OFF_DIV) begin
        // zero is out of range; keep one as the floor
        s_next.div = (wdata[7:0] == 8'h00) ? 8'h01 : wdata[7:0];
      end else if (addr == `I2CMCE_OFF_MASK) begin
        s_next.mask = wdata[0];
      end else if (addr == `I2CMCE_OFF_CLR) begin
        if (wdata[0]) begin
          s_next.raw = 1'b0;
        end
      end else if (addr == `I2CMCE_OFF_CMD) begin
        // busy blocks new commands; illegal ones are nops
        if (!s_reg.busy &&
            cmd_legal(s_reg.mode, c, s_reg.addr_sel[0])) begin
          s_next.busy = 1'b1;
          s_next.do_start = c[`I2CMCE_START];
          s_next.do_xfer = c[`I2CMCE_RUN];
          s_next.do_stop = c[`I2CMCE_STOP];
          s_next.ack = c[`I2CMCE_ACK];
          s_next.err = 1'b0;
          s_next.adr_nak = 1'b0;
          s_next.dat_nak = 1'b0;
          s_next.rx = c[`I2CMCE_START] ? s_reg.addr_sel[0]
                      : (s_reg.mode == I2CMCE_MRX);
          s_next.q = 2'd0;
          s_next.ph = 5'd0;
          s_next.bitn = 4'd0;
          if (c[`I2CMCE_START]) begin
            s_next.seq = I2CMCE_SQ_START;
          end else if (c[`I2CMCE_RUN]) begin
            s_next.seq = I2CMCE_SQ_DATA;
            s_next.sh = s_reg.data;
          end else begin
            s_next.seq = I2CMCE_SQ_STOP;
          end
        end
      end
    end
    // quarter timing: four quarters per bit, QTR_TICKS ticks each
    if (tick) begin
      s_next.ph = qend ? 5'd0 : s_reg.ph + 5'd1;
      if (qend) begin
        s_next.q = s_reg.q + 2'd1;
      end
    end
    // bus sequencer, acts on quarter edges
    if (qend) begin
      case (s_reg.seq)
        I2CMCE_SQ_START: begin
          // q0 release sda, q1 scl high, q2 sda low, q3 scl low
          if (s_reg.q == 2'd0) begin
            s_next.sda_oe = 1'b0;
          end else if (s_reg.q == 2'd1) begin
            s_next.scl_oe = 1'b0;
          end else if (s_reg.q == 2'd2) begin
            s_next.sda_oe = 1'b1;
          end else begin
            s_next.scl_oe = 1'b1;
            s_next.seq = I2CMCE_SQ_ADDR;
            s_next.sh = s_reg.addr_sel;
            s_next.bitn = 4'd0;
          end
        end
        I2CMCE_SQ_ADDR, I2CMCE_SQ_DATA: begin
          // q0 drive bit, q1 scl high, q2 sample, q3 scl low
          if (s_reg.q == 2'd0) begin
            if (s_reg.bitn == 4'd8) begin
              // ack slot: master drives only when receiving data
              s_next.sda_oe = (s_reg.seq == I2CMCE_SQ_DATA) && s_reg.rx &&
                              s_reg.ack;
            end else if (s_reg.seq == I2CMCE_SQ_DATA && s_reg.rx) begin
              s_next.sda_oe = 1'b0;
            end else begin
              s_next.sda_oe = !s_reg.sh[7];
            end
          end else if (s_reg.q == 2'd1) begin
            s_next.scl_oe = 1'b0;
          end else if (s_reg.q == 2'd2) begin
            if (s_reg.bitn == 4'd8) begin
              if (!(s_reg.seq == I2CMCE_SQ_DATA && s_reg.rx) && sda_s) begin
                s_next.adr_nak = (s_reg.seq == I2CMCE_SQ_ADDR);
                s_next.dat_nak = (s_reg.seq == I2CMCE_SQ_DATA);
                s_next.err = 1'b1;
              end
            end else begin
              s_next.sh = {s_reg.sh[6:0], sda_s};
            end
          end else begin
            s_next.scl_oe = 1'b1;
            s_next.bitn = s_reg.bitn + 4'd1;
            if (s_reg.bitn == 4'd8) begin
              phend = 1'b1;
            end
          end
        end
        I2CMCE_SQ_STOP: begin
          // q0 sda low, q1 scl high, q2 sda high
          if (s_reg.q == 2'd0) begin
            s_next.sda_oe = 1'b1;
          end else if (s_reg.q == 2'd1) begin
            s_next.scl_oe = 1'b0;
          end else if (s_reg.q == 2'd2) begin
            s_next.sda_oe = 1'b0;
          end else begin
            s_next.seq = I2CMCE_SQ_END;
          end
        end
        default: begin
          s_next.seq = s_reg.seq;
        end
      endcase
    end
    // end of a byte or address phase
    if (phend) begin
      s_next.bitn = 4'd0;
      if (s_reg.err) begin
        // abort with stop on any nack
        s_next.seq = I2CMCE_SQ_STOP;
        s_next.do_stop = 1'b1;
      end else if (s_reg.seq == I2CMCE_SQ_ADDR) begin
        s_next.seq = I2CMCE_SQ_DATA;
        s_next.sh = s_reg.data;
      end else begin
        if (s_reg.rx) begin
          s_next.data = s_reg.sh;
        end
        s_next.seq = s_reg.do_stop ? I2CMCE_SQ_STOP : I2CMCE_SQ_END;
      end
    end
    // completion: mode update and interrupt
    if (s_reg.seq == I2CMCE_SQ_END) begin
      s_next.seq = I2CMCE_SQ_IDLE;
      s_next.busy = 1'b0;
      s_next.raw = 1'b1;
      if (s_reg.do_stop) begin
        s_next.mode = I2CMCE_IDLE;
      end else if (s_reg.rx) begin
        s_next.mode = I2CMCE_MRX;
      end else begin
        s_next.mode = I2CMCE_MTX;
      end
    end
    s_next.irq = s_next.raw & s_next.mask;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.div <= `I2CMCE_DIV_RST;
      s_reg.mode <= I2CMCE_IDLE;
      s_reg.seq <= I2CMCE_SQ_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign rdata = s_reg.rdata;
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = s_reg.scl_oe;
  assign sda_oe = s_reg.sda_oe;
  assign irq = s_reg.irq;

  // ****************************************
  // checks
  // ****************************************
  a_irq_gate: assert property (@(posedge clk) disable iff (rst)
    irq == (s_reg.raw & s_reg.mask))
    else $error("irq not raw and mask");
  a_clr_drops: assert property (@(posedge clk) disable iff (rst)
    wr && addr == `I2CMCE_OFF_CLR && wdata[0] &&
    s_reg.seq != I2CMCE_SQ_END |=> !s_reg.raw)
    else $error("clear did not drop raw");
  a_busy_ignore: assert property (@(posedge clk) disable iff (rst)
    s_reg.busy && wr && addr == `I2CMCE_OFF_DATA |=> $stable(s_reg.data)
      || $past(s_reg.rx))
    else $error("data changed while busy");
  a_done_raw: assert property (@(posedge clk) disable iff (rst)
    s_reg.seq == I2CMCE_SQ_END |=> s_reg.raw && !s_reg.busy)
    else $error("completion not flagged");
  a_div_floor: assert property (@(posedge clk) disable iff (rst)
    s_reg.div != 8'h00)
    else $error("divider zero");
  a_nop_cmd: assert property (@(posedge clk) disable iff (rst)
    !s_reg.busy && wr && addr == `I2CMCE_OFF_CMD &&
    !cmd_legal(s_reg.mode, wdata[3:0], s_reg.addr_sel[0]) |=> !s_reg.busy)
    else $error("illegal command started");
  a_stop_idle: assert property (@(posedge clk) disable iff (rst)
    s_reg.seq == I2CMCE_SQ_END && s_reg.do_stop |=>
      s_reg.mode == I2CMCE_IDLE)
    else $error("stop did not return idle");
  a_run_needed: assert property (@(posedge clk) disable iff (rst)
    !s_reg.busy && wr && addr == `I2CMCE_OFF_CMD && !wdata[0] &&
    !wdata[2] |=> !s_reg.busy)
    else $error("transfer without run");
endmodule

// *** tb/i2cmce_slave.sv ***
// ****************************************************************
// behavioural i2c slave on the far side of the engine
// ****************************************************************
module i2cmce_slave
(
  // bus lines, high when released thanks to the pull-ups
  input wire logic scl,
  input wire logic sda,
  output logic sda_pull,
  // behaviour control from the bench
  input wire logic [7:0] tx_byte,
  input wire logic nak_addr,
  // observation for the bench
  output logic [7:0] last_byte,
  output logic mack,
  output int n_start,
  output int n_stop
);
  timeunit 1ns;
  timeprecision 1ps;
  int idx; // bit slot within a frame, 8 is the ack slot
  logic active; // frame open since the last start
  logic first; // current frame byte is the address
  logic rd; // slave is the talker for data bytes
  logic [7:0] sh; // incoming shift register
  initial begin
    sda_pull = 1'b0;
    {active, first, rd, mack} = 4'h0;
    {idx, n_start, n_stop} = '0;
    {last_byte, sh} = 16'h0000;
  end
  // start or repeated start: sda falls while scl is high
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      n_start++;
      idx = 0;
      {active, first, rd} = 3'h6;
    end
  end
  // stop: sda rises while scl is high
  always @(posedge sda) begin
    if (scl === 1'b1 && active) begin
      n_stop++;
      active = 1'b0;
    end
  end
  // sample on the rising edge, the only time sda is stable
  always @(posedge scl) begin
    if (active) begin
      if (idx < 8) sh = {sh[6:0], sda};
      if (idx == 7) last_byte = sh;
      if (idx == 7 && first) rd = sh[0];
      if (idx == 8) begin
        // a master nack ends our talking, so a restart is not blocked
        if (rd && !first) mack = !sda;
        if (rd && !first) rd = !sda;
        if (first && nak_addr) rd = 1'b0;
        first = 1'b0;
        idx = 0;
      end else begin
        idx++;
      end
    end
  end
  // change sda only while scl is low: ack slot or read data bit
  always @(negedge scl) begin
    sda_pull = active && (idx == 8 ? (first ? !nak_addr : !rd)
                          : (rd && !first && !tx_byte[7 - idx]));
  end
endmodule

// *** tb/testbench.sv ***
`include "i2cmce_consts.svh"
module testbench
  import i2cmce_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // signals and instances
  // ****************************************************************
  logic clk, rst, wr, rd, scl_oe, sda_oe, s_pull, irq, nak_addr, mack;
  logic scl, sda, scl_d;
  logic [7:0] addr, tx_byte, last_byte;
  logic [31:0] wdata, rdata, v;
  logic [15:0] r; // row: rs, cmd, kind, {start, stop, idle, no-op}
  int n_start, n_stop, s0, p0, cyc, t_rise, per;
  int n_mismatch = 0;
  int n_compared = 0;
  // wired-and lines with pull-ups; slave never stretches scl
  assign scl = !scl_oe;
  assign sda = !(sda_oe | s_pull);
  i2cmce_top i_i2cmce_top (.clk(clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .scl_in(scl),
    .scl_out(), .scl_oe(scl_oe), .sda_in(sda), .sda_out(),
    .sda_oe(sda_oe), .irq(irq));
  i2cmce_slave i_i2cmce_slave (.scl(scl), .sda(sda), .sda_pull(s_pull),
    .tx_byte(tx_byte), .nak_addr(nak_addr), .last_byte(last_byte),
    .mack(mack), .n_start(n_start), .n_stop(n_stop));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // scl period in system clocks, sampled on clk to avoid races
  always @(posedge clk) begin
    cyc <= cyc + 1;
    scl_d <= scl;
    if (scl && !scl_d) begin
      per <= cyc - t_rise;
      t_rise <= cyc;
    end
  end
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  // bounded poll of the raw pending bit
  task automatic wait_done;
    int k;
    for (k = 0; k < 3000; k++) begin
      rd_reg(`I2CMCE_OFF_RAW);
      if (v[0] === 1'b1) break;
    end
    if (k == 3000) begin
      n_mismatch++;
      $display("BAD completion expected 1 seen 0");
      test_done();
    end
  endtask
  task automatic xfer(input logic rs, input logic [3:0] c,
                      input logic [7:0] pat);
    s0 = n_start;
    p0 = n_stop;
    tx_byte <= ~pat;
    wr_reg(`I2CMCE_OFF_ADDR, {24'h0, 7'h2d, rs});
    wr_reg(`I2CMCE_OFF_DATA, {24'h0, pat});
    wr_reg(`I2CMCE_OFF_CMD, {28'h0, c});
  endtask
  // ****************************************************************
  // command walk through idle, transmit and receive states
  // ****************************************************************
  // stops in receive follow a nacked byte; three rows are illegal no-op codes
  logic [15:0] rows [26] = '{16'h071e, 16'h0318, 16'h0110, 16'h0318,
    16'h1b28, 16'h0120, 16'h1328, 16'h0318, 16'h0516, 16'h1328,
    16'h0406, 16'h1b28, 16'h0920, 16'h0526, 16'h172e, 16'h0403,
    16'h0203, 16'h0318, 16'h071e, 16'h1b28, 16'h0201, 16'h071e,
    16'h1b28, 16'h172e, 16'h0318, 16'h0406};
  initial begin
    {rst, wr, rd, nak_addr} = 4'h8;
    addr = 8'h00;
    wdata = 32'h0;
    tx_byte = 8'h00;
    repeat (10) @(posedge clk);
    chk("oe in reset", 0, {scl_oe, sda_oe, irq});
    rst <= 1'b0;
    rd_reg(`I2CMCE_OFF_DIV);
    chk("divider reset", 1, v);
    rd_reg(`I2CMCE_OFF_MASK);
    chk("mask reset", 0, v);
    rd_reg(`I2CMCE_OFF_MIS);
    chk("masked reset", 0, v);
    wr_reg(8'h40, 32'h5);
    rd_reg(8'h40);
    chk("unmapped", 0, v);
    wr_reg(`I2CMCE_OFF_MASK, 32'h1);
    for (int i = 0; i < 26; i++) begin
      r = rows[i];
      xfer(r[12], r[11:8], 8'h40 + 8'(i));
      if (r[0]) begin
        repeat (400) @(posedge clk);
        rd_reg(`I2CMCE_OFF_RAW);
        chk("raw after nop", 0, v);
      end else begin
        wait_done();
        chk("irq", 1, irq);
        wr_reg(`I2CMCE_OFF_CLR, 32'h1);
      end
      chk("starts", r[3], n_start - s0);
      chk("stops", r[2], n_stop - p0);
      rd_reg(`I2CMCE_OFF_CMD);
      chk("idle", r[1], v[5]);
      if (r[7:4] == 4'h1) chk("sent", 8'h40 + 8'(i), last_byte);
      if (r[7:4] == 4'h2) begin
        rd_reg(`I2CMCE_OFF_DATA);
        chk("received", {24'h0, ~(8'h40 + 8'(i))}, v);
        chk("master ack", r[11], mack);
      end
    end
    // address nack aborts with error and stop
    nak_addr <= 1'b1;
    xfer(1'b0, 4'h7, 8'h11);
    wait_done();
    rd_reg(`I2CMCE_OFF_CMD);
    chk("abort status", 8'h26, v[5:0]);
    chk("abort stop", 1, n_stop - p0);
    nak_addr <= 1'b0;
    wr_reg(`I2CMCE_OFF_CLR, 32'h1);
    // writes during a transfer are dropped, interrupt masked
    wr_reg(`I2CMCE_OFF_MASK, 32'h0);
    xfer(1'b0, 4'h7, 8'h5a);
    wr_reg(`I2CMCE_OFF_DATA, 32'ha5);
    wr_reg(`I2CMCE_OFF_CMD, 32'h3);
    wait_done();
    chk("masked irq", 0, irq);
    chk("busy byte", 8'h5a, last_byte);
    rd_reg(`I2CMCE_OFF_CMD);
    chk("busy cmd", 1, v[5]);
    rd_reg(`I2CMCE_OFF_MIS);
    chk("masked bit", 0, v);
    wr_reg(`I2CMCE_OFF_MASK, 32'h1);
    rd_reg(`I2CMCE_OFF_MIS);
    chk("masked set", 1, v);
    chk("irq unmasked", 1, irq);
    wr_reg(`I2CMCE_OFF_CLR, 32'h0);
    rd_reg(`I2CMCE_OFF_RAW);
    chk("clear zero", 1, v);
    wr_reg(`I2CMCE_OFF_CLR, 32'h1);
    rd_reg(`I2CMCE_OFF_RAW);
    chk("clear one", 0, v);
    chk("irq cleared", 0, irq);
    // scl period with divider two; zero is held at one
    wr_reg(`I2CMCE_OFF_DIV, 32'h0);
    rd_reg(`I2CMCE_OFF_DIV);
    chk("divider zero", 1, v);
    wr_reg(`I2CMCE_OFF_DIV, 32'h2);
    xfer(1'b0, 4'h3, 8'hc3);
    wait_done();
    chk("scl period", 2 * 3 * (`I2CMCE_LOW_PHASE + `I2CMCE_HIGH_PHASE),
        per);
    wr_reg(`I2CMCE_OFF_CLR, 32'h1);
    xfer(1'b0, 4'h4, 8'h00);
    wait_done();
    chk("final stop", 1, n_stop - p0);
    test_done();
  end
endmodule
